// ---- dpm_mac_unit.sv ----
// Dot-product multiply-accumulate datapath with four accumulators.
// It never stalls and never raises an exception; overflow is seen only
// through the flag bits and through clamped results.
// Assumes the pipeline issues one request per cycle, on the core clock.
module dpm_mac_unit (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Decoded request from the pipeline.
  input dpm_pkg::dpm_req_t req,
  // Raw instruction word, decoded for the word fractional subtract.
  input wire logic raw_valid,
  input wire logic [31:0] raw_instr,
  input wire logic [31:0] raw_first_source,
  input wire logic [31:0] raw_second_source,
  // Control register write port from the pipeline.
  input wire logic ctrl_we,
  input wire logic [31:0] ctrl_wdata,
  // Results.
  output logic [3:0][63:0] acc_out,
  output logic [31:0] signal_processing_control_register,
  output logic op_done
);

  // Whole state of the unit, and its value for the next edge.
  dpm_pkg::dpm_state_t state_reg;
  dpm_pkg::dpm_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Q15 multiply with saturation of the minus-one square.
  // That square is the only Q15 product with no Q31 image.
  function automatic logic [32:0] q15_mul(input logic [15:0] a,
                                          input logic [15:0] b);
    logic [31:0] p;
    p = 32'($signed(a) * $signed(b));
    if (a == dpm_pkg::Q15_MINUS_ONE && b == dpm_pkg::Q15_MINUS_ONE) begin
      q15_mul = {1'b1, dpm_pkg::Q31_MAX}; // RULE_08
    end else begin
      q15_mul = {1'b0, p[30:0], 1'b0}; // RULE_07
    end
  endfunction

  // Signed halfword product, sign-extended to accumulator width.
  // Products are full size, so only the 64-bit sum can wrap.
  function automatic logic [63:0] int_mul(input logic [15:0] a,
                                          input logic [15:0] b);
    logic [31:0] p;
    p = 32'($signed(a) * $signed(b));
    int_mul = {{32{p[31]}}, p};
  endfunction

  // Sign extension of a Q31 value.
  function automatic logic [63:0] sx32(input logic [31:0] v);
    sx32 = {{32{v[31]}}, v};
  endfunction

  // Accumulator minus the sum of two Q15 products; bit 64 of the result
  // reports that either product was clamped.
  function automatic logic [64:0] frac_pair_sub(input logic [63:0] acc,
                                                input logic [32:0] pa,
                                                input logic [32:0] pb);
    logic [63:0] dotp;
    dotp = sx32(pa[31:0]) + sx32(pb[31:0]);
    frac_pair_sub = {pa[32] | pb[32], acc - dotp};
  endfunction

  // Q31 word product doubled into Q63. The minus-one square has no Q63
  // image, so it clamps to the largest positive value; bit 64 marks it.
  function automatic logic [64:0] q31_mul(input logic [31:0] a,
                                          input logic [31:0] b);
    logic [63:0] p;
    p = 64'($signed(a) * $signed(b));
    if (a == dpm_pkg::Q31_MINUS_ONE && b == dpm_pkg::Q31_MINUS_ONE) begin
      q31_mul = {1'b1, dpm_pkg::Q63_MAX};
    end else begin
      q31_mul = {1'b0, p[62:0], 1'b0};
    end
  endfunction

  // Q63 subtract that clamps instead of wrapping; bit 64 marks a clamp.
  // Overflow is only possible when the operand signs differ and the
  // result takes the sign of the subtrahend.
  function automatic logic [64:0] q63_sub(input logic [63:0] acc,
                                          input logic [63:0] prod);
    logic [63:0] diff;
    diff = acc - prod;
    if (!acc[63] && prod[63] && diff[63]) begin
      q63_sub = {1'b1, dpm_pkg::Q63_MAX}; // RULE_11
    end else if (acc[63] && !prod[63] && !diff[63]) begin
      q63_sub = {1'b1, dpm_pkg::Q63_MIN}; // RULE_11
    end else begin
      q63_sub = {1'b0, diff};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state computation.
  always_comb begin
    // Working values; r starts as req, word_op is decoded, the rest start at zero so no path holds a stale one.
    dpm_pkg::dpm_req_t r;
    logic [63:0] cur;
    logic [63:0] res;
    logic [32:0] pa;
    logic [32:0] pb;
    logic [63:0] prod;
    logic sat;
    logic sat_acc;
    logic word_op;
    r = req;
    cur = '0;
    res = '0;
    pa = '0;
    pb = '0;
    prod = '0;
    sat = 1'b0;
    sat_acc = 1'b0;
    // Start from the held state; done is a one-cycle pulse.
    state_next = state_reg;
    state_next.done = 1'b0;
    // Fixed-field decode of the word fractional subtract.
    word_op = raw_valid
      && raw_instr[31:dpm_pkg::MAJOR_LSB] == dpm_pkg::MAJOR_OPCODE_GROUP
      && raw_instr[13:dpm_pkg::MINOR_LSB] == dpm_pkg::MINOR_FRAC_WORD_SUB
      && raw_instr[5:0] == dpm_pkg::EXTENDED_FUNCTION_GROUP; // RULE_14
    if (word_op) begin
      r.valid = 1'b1;
      r.op = dpm_pkg::DPM_OP_FRACTIONAL_WORD_SUBTRACT_SATURATING;
      r.accumulator_index = raw_instr[15:dpm_pkg::ACC_IDX_LSB];
      r.second_source_register = raw_second_source;
      r.first_source_register = raw_first_source;
    end
    // A control write lands; a saturation below still sets its flag bit over it.
    if (ctrl_we) begin
      state_next.ctrl = ctrl_wdata; // RULE_17
    end
    // Only the selected accumulator moves; the other three hold.
    if (r.valid) begin
      cur = state_reg.acc[r.accumulator_index]; // RULE_02
      unique case (r.op)
        // Unsigned byte products are zero-extended; no flag moves.
        dpm_pkg::DPM_OP_UNSIGNED_BYTE_RIGHT_ACCUMULATE: begin
          prod = 64'(r.first_source_register[15:8]
                     * r.second_source_register[15:8])
               + 64'(r.first_source_register[7:0]
                     * r.second_source_register[7:0]);
          res = cur + prod; // RULE_01 RULE_03
        end
        // Upper halfword of one source meets the lower of the other.
        dpm_pkg::DPM_OP_INTEGER_CROSS_ACCUMULATE: begin
          res = cur
            + int_mul(r.first_source_register[31:16],
                      r.second_source_register[15:0])
            + int_mul(r.first_source_register[15:0],
                      r.second_source_register[31:16]); // RULE_04 RULE_05
        end
        // Matching halfwords; the 64-bit difference simply wraps.
        dpm_pkg::DPM_OP_INTEGER_HALFWORD_SUBTRACT: begin
          res = cur
            - (int_mul(r.first_source_register[31:16],
                       r.second_source_register[31:16])
            + int_mul(r.first_source_register[15:0],
                      r.second_source_register[15:0])); // RULE_06 RULE_05
        end
        // Matching Q15 halfwords; only the products may clamp.
        dpm_pkg::DPM_OP_FRACTIONAL_HALFWORD_SUBTRACT: begin
          pa = q15_mul(r.first_source_register[31:16],
                       r.second_source_register[31:16]);
          pb = q15_mul(r.first_source_register[15:0],
                       r.second_source_register[15:0]);
          {sat, res} = frac_pair_sub(cur, pa, pb); // RULE_09
        end
        // Crossed Q15 halfwords; only the products may clamp.
        dpm_pkg::DPM_OP_FRACTIONAL_CROSS_SUBTRACT: begin
          pa = q15_mul(r.first_source_register[31:16],
                       r.second_source_register[15:0]);
          pb = q15_mul(r.first_source_register[15:0],
                       r.second_source_register[31:16]);
          {sat, res} = frac_pair_sub(cur, pa, pb); // RULE_13
        end
        dpm_pkg::DPM_OP_FRACTIONAL_WORD_SUBTRACT_SATURATING: begin
          // Product clamp and accumulator clamp both raise the flag.
          {sat, prod} = q31_mul(r.first_source_register,
                                r.second_source_register);
          {sat_acc, res} = q63_sub(cur, prod); // RULE_11
          sat = sat | sat_acc; // RULE_12
        end
        // An empty or illegal code leaves the accumulator as it was.
        default: begin
          res = cur;
        end
      endcase
      // Commit the result and raise the done pulse.
      if (r.op != dpm_pkg::DPM_OP_NONE) begin
        state_next.acc[r.accumulator_index] = res;
        state_next.done = 1'b1;
      end
      // Set wins over a same-cycle control write.
      if (sat) begin
        state_next.ctrl[dpm_pkg::FLAG_BASE + 32'(r.accumulator_index)] =
          1'b1; // RULE_10 RULE_12 RULE_08 RULE_17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; no result path raises an exception.
  // Reset loads constants only; flags and accumulators restart clear.
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg.acc <= {dpm_pkg::ACC_COUNT{dpm_pkg::ACC_RESET}};
      state_reg.ctrl <= dpm_pkg::CTRL_RESET;
      state_reg.done <= 1'b0;
    end else begin
      state_reg <= state_next; // RULE_15
    end
  end

  // Outputs come straight from the state register.
  assign acc_out = state_reg.acc;
  assign signal_processing_control_register = state_reg.ctrl;
  assign op_done = state_reg.done;

endmodule

// ---- dpm_mac_unit_monitor.sv ----
// Port checker for the dot-product unit.
// Sees only the unit's ports; the bind at the foot attaches it.
module dpm_mac_unit_monitor (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Requests.
  input dpm_pkg::dpm_req_t req,
  input wire logic raw_valid,
  input wire logic ctrl_we,
  // Results.
  input wire logic [3:0][63:0] acc_out,
  input wire logic [31:0] signal_processing_control_register,
  input wire logic op_done
);
  logic go;
  logic [1:0] ix;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] spcr;
  logic [3:0] fl;
  logic [63:0] bsum;
  // Aliases; op codes 1 to 6 follow the package's enum order.
  assign go = req.valid && req.op != dpm_pkg::DPM_OP_NONE && !raw_valid;
  assign ix = req.accumulator_index;
  assign a = req.first_source_register;
  assign b = req.second_source_register;
  assign spcr = signal_processing_control_register;
  assign fl = spcr[19:16];
  assign bsum = acc_out[ix] + 64'(a[15:8]) * 64'(b[15:8])
    + 64'(a[7:0]) * 64'(b[7:0]);
  // All checks sample on the core clock and rest during reset.
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_done_pulse: assert property (go |=> op_done)
    else $error("no done pulse");
  chk_flags_sticky: assert property (
    !ctrl_we && !reset |=> (fl & $past(fl)) == $past(fl))
    else $error("flag cleared");
  chk_byte_no_flag: assert property (
    go && req.op == 3'h1 && !ctrl_we |=> $stable(fl)) else $error("flag");
  chk_int_no_flag: assert property (
    go && req.op inside {3'h2, 3'h3} && !ctrl_we |=> $stable(fl))
    else $error("int flag");
  chk_byte_sum: assert property (
    go && req.op == 3'h1 |=> acc_out[$past(ix)] == $past(bsum))
    else $error("byte sum");
  chk_other_acc_hold: assert property (
    go |=> acc_out[$past(ix) + 2'd1] == $past(acc_out[ix + 2'd1]))
    else $error("wrong accumulator");
  chk_half_flag_bit: assert property (
    go && req.op == 3'h4 && a == 32'h8000_8000 && b == a
    |=> spcr[16 + $past(ix)]) else $error("half flag");
  chk_word_flag_bit: assert property (
    go && req.op == 3'h5 && a == 32'h8000_0000 && b == a
    |=> spcr[16 + $past(ix)]) else $error("word flag");
  cover property (go && req.op == 3'h5);
  cover property ($rose(fl[3]));
  cover property (raw_valid ##1 op_done);
endmodule

bind dpm_mac_unit dpm_mac_unit_monitor i_monitor (.mclk(mclk),
  .reset(reset), .req(req), .raw_valid(raw_valid), .ctrl_we(ctrl_we),
  .acc_out(acc_out), .op_done(op_done),
  .signal_processing_control_register(signal_processing_control_register));

// ---- dpm_mac_unit_tb_top.sv ----
// Self-checking bench for the dot-product unit.
// Assumes the pipeline stand-in and the bound port checker.
module dpm_mac_unit_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk;
  logic reset;
  dpm_pkg::dpm_req_t req;
  logic raw_valid;
  logic ctrl_we;
  logic [31:0] raw_instr;
  logic [31:0] raw_first_source;
  logic [31:0] raw_second_source;
  logic [31:0] ctrl_wdata;
  logic [31:0] spcr;
  logic [3:0][63:0] acc_out;
  logic op_done;
  longint m[4];
  logic [31:0] mc = '0;
  logic md = 1'b0;
  logic sat;
  int errors;
  int num_checks;
  dpm_mac_unit i_dut (.mclk(mclk), .reset(reset), .req(req),
    .raw_valid(raw_valid), .raw_instr(raw_instr),
    .raw_first_source(raw_first_source),
    .raw_second_source(raw_second_source), .ctrl_we(ctrl_we),
    .ctrl_wdata(ctrl_wdata), .acc_out(acc_out),
    .signal_processing_control_register(spcr), .op_done(op_done));
  dpm_pipe_model i_pipe (.mclk(mclk), .req(req), .raw_valid(raw_valid),
    .raw_instr(raw_instr), .raw_first_source(raw_first_source),
    .raw_second_source(raw_second_source), .ctrl_we(ctrl_we),
    .ctrl_wdata(ctrl_wdata));
  // Core clock, 10 ns period.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Sign-extended halfword.
  function automatic longint hw(logic [15:0] x);
    return longint'($signed(x));
  endfunction
  // Q15 product with the minus-one-squared clamp.
  function automatic longint q15(logic [15:0] x, logic [15:0] y);
    if (x == 16'h8000 && y == 16'h8000) begin
      sat = 1'b1;
      return 64'h0000_0000_7FFF_FFFF;
    end
    return longint'(int'($signed(x)) * int'($signed(y)) * 2);
  endfunction
  // Reference model: one accepted op plus any control write.
  task automatic apply(int o, int i, logic [31:0] a, logic [31:0] b,
                       logic we, logic [31:0] wd);
    longint p;
    longint r;
    sat = 1'b0;
    case (o)
      1: m[i] += a[15:8] * b[15:8] + a[7:0] * b[7:0];
      2: m[i] += hw(a[31:16]) * hw(b[15:0]) + hw(a[15:0]) * hw(b[31:16]);
      3: m[i] -= hw(a[31:16]) * hw(b[31:16]) + hw(a[15:0]) * hw(b[15:0]);
      4: m[i] -= q15(a[31:16], b[31:16]) + q15(a[15:0], b[15:0]);
      6: m[i] -= q15(a[31:16], b[15:0]) + q15(a[15:0], b[31:16]);
      5: begin
        sat = a == 32'h8000_0000 && b == a;
        p = sat ? dpm_pkg::Q63_MAX : hw(a[31:16]) * 0 + longint'($signed(a))
          * longint'($signed(b)) * 2;
        r = m[i] - p;
        if ((m[i] < 0) != (p < 0) && (r < 0) != (m[i] < 0)) begin
          r = (m[i] < 0) ? dpm_pkg::Q63_MIN : dpm_pkg::Q63_MAX;
          sat = 1'b1;
        end
        m[i] = r;
      end
      default: ;
    endcase
    if (we) mc = wd;
    if (sat) mc[16 + i] = 1'b1;
  endtask
  // Counts a comparison and reports a difference.
  task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Issues one cycle, checks the previous cycle's results, then models it.
  task automatic step(dpm_pkg::dpm_req_t r, logic rv, logic [31:0] ri,
                      logic we, logic [31:0] wd);
    logic hit;
    logic [31:0] a;
    logic [31:0] b;
    a = r.first_source_register;
    b = r.second_source_register;
    hit = rv && {ri[31:26], ri[13:0]} == {dpm_pkg::MAJOR_OPCODE_GROUP,
      dpm_pkg::MINOR_FRAC_WORD_SUB, dpm_pkg::EXTENDED_FUNCTION_GROUP};
    i_pipe.send(r, rv, ri, b, a, we, wd);
    #1;
    for (int k = 0; k < 4; k++) chk("acc", acc_out[k], m[k]);
    chk("flags", 64'(spcr), 64'(mc));
    chk("done", 64'(op_done), 64'(md));
    md = hit || r.valid && r.op != dpm_pkg::DPM_OP_NONE;
    if (hit) apply(5, ri[15:14], b, a, we, wd);
    else apply(r.valid ? int'(r.op) : 0, r.accumulator_index, a, b, we, wd);
  endtask
  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence: reset, both Q63 limits, random back-to-back traffic,
  // then a second reset and both product clamps.
  initial begin
    dpm_pkg::dpm_req_t r;
    logic [31:0] a;
    logic [31:0] ri;
    reset = 1'b1;
    void'($urandom(91));
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      r = '{1'b1, dpm_pkg::DPM_OP_FRACTIONAL_WORD_SUBTRACT_SATURATING,
        2'(j / 2 + 1), j < 2 ? 32'h8000_0000 : 32'h7FFF_FFFF, 32'h7FFF_FFFF};
      step(r, 1'b0, 32'h0000_0000, 1'b0, 32'h0000_0000);
    end
    for (int n = 0; n < 300; n++) begin
      a = $urandom_range(2) == 0 ? 32'h8000_8000 : $urandom;
      if ($urandom_range(9) == 0) a = 32'h8000_0000;
      r = '{$urandom_range(7) != 0, dpm_pkg::dpm_op_t'($urandom_range(6)),
        2'($urandom), a, $urandom_range(1) ? a : $urandom};
      ri = {dpm_pkg::MAJOR_OPCODE_GROUP, 12'($urandom),
        dpm_pkg::MINOR_FRAC_WORD_SUB ^ 8'($urandom_range(7) == 0),
        dpm_pkg::EXTENDED_FUNCTION_GROUP};
      step(r, $urandom_range(3) == 0, ri, $urandom_range(7) == 0, $urandom);
    end
    step('0, 1'b0, '0, 1'b0, '0);
    // Mid-run reset clears every accumulator, flag and done pulse.
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    m = '{0, 0, 0, 0};
    mc = '0;
    // Both product clamps, each on its own accumulator.
    r = '{1'b1, dpm_pkg::DPM_OP_FRACTIONAL_WORD_SUBTRACT_SATURATING, 2'h3,
      32'h8000_0000, 32'h8000_0000};
    step(r, 1'b0, 32'h0000_0000, 1'b0, 32'h0000_0000);
    r = '{1'b1, dpm_pkg::DPM_OP_FRACTIONAL_HALFWORD_SUBTRACT, 2'h0,
      32'h8000_8000, 32'h8000_8000};
    step(r, 1'b0, 32'h0000_0000, 1'b0, 32'h0000_0000);
    step('0, 1'b0, '0, 1'b0, '0);
    tally_and_finish;
  end
  // Watchdog, far beyond the few hundred cycles the run needs.
  initial begin
    repeat (4000) @(posedge mclk);
    errors++;
    tally_and_finish;
  end
endmodule

// ---- dpm_pipe_model.sv ----
// Stand-in for the issuing pipeline stage.
// Assumes one send call per cycle from the bench's main thread.
module dpm_pipe_model (
  // Clock.
  input wire logic mclk,
  // Requests and control writes toward the unit.
  output dpm_pkg::dpm_req_t req,
  output logic raw_valid,
  output logic [31:0] raw_instr,
  output logic [31:0] raw_first_source,
  output logic [31:0] raw_second_source,
  output logic ctrl_we,
  output logic [31:0] ctrl_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Everything idle at time zero.
  initial begin
    {req, raw_valid, raw_instr, raw_first_source, raw_second_source,
      ctrl_we, ctrl_wdata} = '0;
  end
  // Launches one cycle of signals just after a rising edge.
  task automatic send(dpm_pkg::dpm_req_t r, logic rv, logic [31:0] ri,
                      logic [31:0] ra, logic [31:0] rb, logic we,
                      logic [31:0] wd);
    @(posedge mclk);
    {req, raw_valid, raw_instr, raw_first_source, raw_second_source,
      ctrl_we, ctrl_wdata} <= {r, rv, ri, ra, rb, we, wd};
  endtask
endmodule

// ---- dpm_pkg.sv ----
// Constants and carrier types for the dot-product multiply-accumulate unit.
// Assumes a pipeline that hands over decoded operations and operands.
// Function
// RULE_01: Right unsigned byte pairs added into accumulator.
// RULE_02: Four 64-bit accumulators, index zero is legacy.
// RULE_03: Unsigned byte operations never touch overflow flags.
// RULE_04: Cross halfword products added into accumulator.
// RULE_05: Integer halfword operations wrap, flags untouched.
// RULE_06: Matching halfword products subtracted from accumulator.
// RULE_07: Q15 products signed, shifted left one.
// RULE_08: Minus one squared saturates and sets flag.
// RULE_09: Sign-extended product sum subtracted, no clamping.
// RULE_10: Flag bit is sixteen plus accumulator index.
// RULE_11: Word fractional subtract clamps to Q63 limits.
// RULE_12: Word subtract saturation sets selected flag.
// RULE_13: Cross fractional products subtracted from accumulator.
// RULE_14: Word subtract decoded from fixed opcode fields.
// RULE_15: No operand-dependent exceptions are ever raised.
// RULE_16: Issuer must supply correctly formatted operands.
// RULE_17: Flags are sticky, cleared only by writes.
package dpm_pkg;

  localparam int ACC_COUNT = 4;
  localparam int ACC_WIDTH = 64;
  localparam int CTRL_WIDTH = 32;
  localparam int FLAG_BASE = 16;
  localparam logic [63:0] ACC_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] Q15_MINUS_ONE = 16'h8000;
  localparam logic [31:0] Q31_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] Q31_MINUS_ONE = 32'h8000_0000;
  localparam logic [63:0] Q63_MAX = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] Q63_MIN = 64'h8000_0000_0000_0000;
  // Instruction word fields.
  localparam int MAJOR_LSB = 26;
  localparam int SECOND_SRC_LSB = 21;
  localparam int FIRST_SRC_LSB = 16;
  localparam int ACC_IDX_LSB = 14;
  localparam int MINOR_LSB = 6;
  localparam logic [5:0] MAJOR_OPCODE_GROUP = 6'h00;
  localparam logic [7:0] MINOR_FRAC_WORD_SUB = 8'h5A;
  localparam logic [5:0] EXTENDED_FUNCTION_GROUP = 6'h3C;

  // Operations the pipeline may issue.
  typedef enum logic [2:0] {
    DPM_OP_NONE,
    DPM_OP_UNSIGNED_BYTE_RIGHT_ACCUMULATE,
    DPM_OP_INTEGER_CROSS_ACCUMULATE,
    DPM_OP_INTEGER_HALFWORD_SUBTRACT,
    DPM_OP_FRACTIONAL_HALFWORD_SUBTRACT,
    DPM_OP_FRACTIONAL_WORD_SUBTRACT_SATURATING,
    DPM_OP_FRACTIONAL_CROSS_SUBTRACT
  } dpm_op_t;

  // One issued request.
  typedef struct packed {
    logic valid;
    dpm_op_t op;
    logic [1:0] accumulator_index;
    logic [31:0] first_source_register;
    logic [31:0] second_source_register;
  } dpm_req_t;

  // Whole state of the unit.
  typedef struct packed {
    logic [ACC_COUNT-1:0][ACC_WIDTH-1:0] acc;
    logic [CTRL_WIDTH-1:0] ctrl;
    logic done;
  } dpm_state_t;

endpackage
